// ### src/uiec_dev_end.sv
`timescale 1ns/1ps
module uiec_dev_end (
  input  wire logic                           core_clk_i,
  input  wire logic                           resetn_i,
  input  wire logic                           ce_i,
  input  wire logic                           iso_mode_i,
  input  wire logic                           double_buffer_enable_i,
  input  wire logic                           hold_until_frame_start_i,
  input  wire logic                           irq_enable_i,
  output logic                                ep_irq_o,
  output logic [uiec_pkg::UIEC_PTR_W-1:0]     fifo_ptr_o,
  output logic [uiec_pkg::UIEC_CNT_W-1:0]     pkt_count_o,
  uiec_link_if.dev                            link
);

  // ---------------------------------------------------------------------------
  // Packet queue and flush sequence
  // ---------------------------------------------------------------------------
  uiec_pkg::uiec_dev_state_t             state, next_state;
  logic [uiec_pkg::UIEC_CNT_W-1:0]       cnt, next_cnt;
  logic                                  held, next_held;
  logic [uiec_pkg::UIEC_PTR_W-1:0]       ptr, next_ptr;
  logic [uiec_pkg::UIEC_CNT_W-1:0]       slots;
  logic                                  stall_live;
  logic                                  has_pkt;
  logic                                  add_pkt;
  logic                                  sub_pkt;
  logic                                  flush_now;
  logic                                  arm_hold;

  // Stall only takes part in bulk/interrupt handling.
  assign stall_live = link.send_stall_request && !iso_mode_i;
  assign slots      = double_buffer_enable_i ? uiec_pkg::UIEC_SLOTS_DOUBLE
                                             : uiec_pkg::UIEC_SLOTS_SINGLE;
  assign has_pkt    = cnt != uiec_pkg::UIEC_CNT_ZERO;
  assign flush_now  = state == uiec_pkg::UIEC_DEV_FLUSH;
  // A packet loaded in frame-hold mode waits outside the queue for the next SOF.
  assign arm_hold   = link.wr_ready && iso_mode_i && hold_until_frame_start_i && !held;

  always_comb begin
    next_state = state;
    next_held  = held;
    next_ptr   = ptr;
    add_pkt    = 1'b0;
    sub_pkt    = 1'b0;
    case (state)
      uiec_pkg::UIEC_DEV_IDLE: begin
        if (link.wr_flush) begin
          next_state = uiec_pkg::UIEC_DEV_FLUSH;
        end
      end
      uiec_pkg::UIEC_DEV_FLUSH: begin
        next_state = uiec_pkg::UIEC_DEV_IDLE;
      end
      default: begin
        next_state = uiec_pkg::UIEC_DEV_IDLE;
      end
    endcase
    // Flush drops the oldest queued packet; a held one counts as next in line.
    if (flush_now) begin
      next_ptr = uiec_pkg::UIEC_PTR_RESET;
      if (has_pkt) begin
        sub_pkt = 1'b1;
      end else if (held) begin
        next_held = 1'b0;
      end
    end else if (link.in_token && has_pkt && !stall_live) begin
      sub_pkt = 1'b1;
    end
    if (link.load_byte && !flush_now) begin
      next_ptr = ptr + uiec_pkg::UIEC_PTR_STEP;
    end
    if (arm_hold) begin
      next_held = 1'b1;
    end else if (link.sof && next_held) begin
      // A held packet just dropped by a flush must not be released as well.
      next_held = 1'b0;
      add_pkt   = 1'b1;
    end else if (link.wr_ready && !(iso_mode_i && hold_until_frame_start_i)) begin
      add_pkt   = 1'b1;
    end
    next_cnt = cnt;
    if (add_pkt && !sub_pkt && cnt != slots) begin
      next_cnt = cnt + uiec_pkg::UIEC_CNT_ONE;
    end else if (sub_pkt && !add_pkt) begin
      next_cnt = cnt - uiec_pkg::UIEC_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= uiec_pkg::UIEC_DEV_IDLE;
      cnt   <= uiec_pkg::UIEC_CNT_ZERO;
      held  <= 1'b0;
      ptr   <= uiec_pkg::UIEC_PTR_RESET;
    end else if (ce_i) begin
      state <= next_state;
      cnt   <= next_cnt;
      held  <= next_held;
      ptr   <= next_ptr;
    end
  end

  // ---------------------------------------------------------------------------
  // Token answers and status bits
  // ---------------------------------------------------------------------------
  uiec_pkg::uiec_resp_t next_kind;
  logic                 next_valid;
  logic                 next_ready;
  logic                 next_stall;
  logic                 next_underrun;
  logic                 next_has;
  logic                 next_busy;
  logic                 next_irq;
  logic                 underrun_set;

  always_comb begin
    next_valid   = 1'b0;
    next_kind    = uiec_pkg::UIEC_RESP_NONE;
    underrun_set = 1'b0;
    if (link.in_token && !flush_now) begin
      next_valid = 1'b1;
      if (stall_live) begin
        next_kind = uiec_pkg::UIEC_RESP_STALL;
      end else if (has_pkt) begin
        next_kind = uiec_pkg::UIEC_RESP_DATA;
      end else if (iso_mode_i) begin
        next_kind    = uiec_pkg::UIEC_RESP_ZLP;
        underrun_set = 1'b1;
      end else begin
        next_kind    = uiec_pkg::UIEC_RESP_NAK;
        underrun_set = 1'b1;
      end
    end else if (link.in_token) begin
      // A token that meets the flush cycle is refused with NAK, or STALL while a stall is live; the queue is moving.
      next_valid = 1'b1;
      next_kind  = stall_live ? uiec_pkg::UIEC_RESP_STALL : uiec_pkg::UIEC_RESP_NAK;
      underrun_set = !stall_live;
    end
    // A new underrun wins over a clear in the same cycle.
    if (underrun_set) begin
      next_underrun = 1'b1;
    end else if (link.clr_underrun) begin
      next_underrun = 1'b0;
    end else begin
      next_underrun = link.underrun_flag;
    end
    next_stall = link.wr_stall ? link.stall_value : link.send_stall_request;
    // Double buffered the flag stands only while no slot is free.
    if (double_buffer_enable_i) begin
      next_ready = next_cnt == slots;
    end else begin
      next_ready = next_cnt != uiec_pkg::UIEC_CNT_ZERO;
    end
    next_has  = (next_cnt != uiec_pkg::UIEC_CNT_ZERO) || next_held;
    next_busy = next_state == uiec_pkg::UIEC_DEV_FLUSH;
    // Every hardware drop of the ready flag, flush included, is an event.
    next_irq  = irq_enable_i && link.in_packet_ready && !next_ready;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.resp_valid         <= 1'b0;
      link.resp_kind          <= uiec_pkg::UIEC_RESP_NONE;
      link.in_packet_ready    <= 1'b0;
      link.send_stall_request <= 1'b0;
      link.underrun_flag      <= 1'b0;
      link.fifo_has_packets   <= 1'b0;
      link.flush_busy         <= 1'b0;
      ep_irq_o                <= 1'b0;
      fifo_ptr_o              <= uiec_pkg::UIEC_PTR_RESET;
      pkt_count_o             <= uiec_pkg::UIEC_CNT_ZERO;
    end else if (ce_i) begin
      link.resp_valid         <= next_valid;
      link.resp_kind          <= next_kind;
      link.in_packet_ready    <= next_ready;
      link.send_stall_request <= next_stall;
      link.underrun_flag      <= next_underrun;
      link.fifo_has_packets   <= next_has;
      link.flush_busy         <= next_busy;
      ep_irq_o                <= next_irq;
      fifo_ptr_o              <= next_ptr;
      pkt_count_o             <= next_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // Notes
  // ---------------------------------------------------------------------------
  // The ready flag is a view of the slot count, so firmware writes of 1 only
  // add a packet; a write while every slot is taken, with no token or flush freeing
  // one in the same cycle, is dropped, since there is no room to queue it and overwriting would corrupt the packet in flight.

endmodule

// ### src/uiec_pkg.sv
package uiec_pkg;

  // ---------------------------------------------------------------------------
  // Answers returned to the host on an IN token
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    UIEC_RESP_NONE  = 3'h0,
    UIEC_RESP_DATA  = 3'h1,
    UIEC_RESP_ZLP   = 3'h2,
    UIEC_RESP_NAK   = 3'h3,
    UIEC_RESP_STALL = 3'h4
  } uiec_resp_t;

  // ---------------------------------------------------------------------------
  // Packet slot accounting
  // ---------------------------------------------------------------------------
  localparam int          UIEC_CNT_W       = 2;
  localparam logic [1:0]  UIEC_CNT_ZERO    = 2'h0;
  localparam logic [1:0]  UIEC_CNT_ONE     = 2'h1;
  localparam logic [1:0]  UIEC_SLOTS_SINGLE = 2'h1;
  localparam logic [1:0]  UIEC_SLOTS_DOUBLE = 2'h2;

  // ---------------------------------------------------------------------------
  // Byte pointer of the endpoint FIFO
  // ---------------------------------------------------------------------------
  localparam int          UIEC_PTR_W       = 10;
  localparam logic [9:0]  UIEC_PTR_RESET   = 10'h000;
  localparam logic [9:0]  UIEC_PTR_STEP    = 10'h001;

  // ---------------------------------------------------------------------------
  // Discard request counter of the far end
  // ---------------------------------------------------------------------------
  localparam int          UIEC_DISC_W      = 4;
  localparam logic [3:0]  UIEC_DISC_ZERO   = 4'h0;
  localparam logic [3:0]  UIEC_DISC_ONE    = 4'h1;
  localparam logic [3:0]  UIEC_DISC_MAX    = 4'hF;

  // ---------------------------------------------------------------------------
  // State machines
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    UIEC_DEV_IDLE  = 1'h0,
    UIEC_DEV_FLUSH = 1'h1
  } uiec_dev_state_t;

  typedef enum logic [1:0] {
    UIEC_HOST_IDLE     = 2'h0,
    UIEC_HOST_WAIT_SET = 2'h1,
    UIEC_HOST_WAIT_CLR = 2'h2
  } uiec_host_state_t;

endpackage

// ### src/uiec_link_if.sv
`timescale 1ns/1ps
interface uiec_link_if;
  // Far end to endpoint: link events and control bit writes.
  logic                   in_token;
  logic                   sof;
  logic                   wr_ready;
  logic                   wr_stall;
  logic                   stall_value;
  logic                   wr_flush;
  logic                   clr_underrun;
  logic                   load_byte;
  // Endpoint to far end: answers and status bits.
  logic                   resp_valid;
  uiec_pkg::uiec_resp_t   resp_kind;
  logic                   in_packet_ready;
  logic                   send_stall_request;
  logic                   underrun_flag;
  logic                   fifo_has_packets;
  logic                   flush_busy;

  modport dev (
    input  in_token, sof, wr_ready, wr_stall, stall_value, wr_flush, clr_underrun, load_byte,
    output resp_valid, resp_kind, in_packet_ready, send_stall_request, underrun_flag,
           fifo_has_packets, flush_busy
  );

  modport host (
    output in_token, sof, wr_ready, wr_stall, stall_value, wr_flush, clr_underrun, load_byte,
    input  resp_valid, resp_kind, in_packet_ready, send_stall_request, underrun_flag,
           fifo_has_packets, flush_busy
  );
endinterface

// ### src/uiec_host_end.sv
`timescale 1ns/1ps
module uiec_host_end (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic       tok_req_i,
  input  wire logic       sof_req_i,
  input  wire logic       load_byte_i,
  input  wire logic       load_done_i,
  input  wire logic       stall_set_i,
  input  wire logic       stall_clr_i,
  input  wire logic       discard_i,
  input  wire logic       clr_underrun_i,
  output logic            resp_valid_o,
  output uiec_pkg::uiec_resp_t resp_kind_o,
  output logic            discard_pending_o,
  uiec_link_if.host       link
);

  // ---------------------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------------------
  uiec_pkg::uiec_host_state_t state, next_state;
  logic [uiec_pkg::UIEC_DISC_W-1:0] disc_cnt, next_disc_cnt;
  logic next_flush;
  logic take;

  always_comb begin
    next_state    = state;
    next_disc_cnt = disc_cnt;
    next_flush    = 1'b0;
    take          = 1'b0;
    case (state)
      uiec_pkg::UIEC_HOST_IDLE: begin
        // One discard write per packet, the next only after the last completed.
        if (disc_cnt != uiec_pkg::UIEC_DISC_ZERO) begin
          next_flush = 1'b1;
          take       = 1'b1;
          next_state = uiec_pkg::UIEC_HOST_WAIT_SET;
        end
      end
      uiec_pkg::UIEC_HOST_WAIT_SET: begin
        if (link.flush_busy) begin
          next_state = uiec_pkg::UIEC_HOST_WAIT_CLR;
        end
      end
      uiec_pkg::UIEC_HOST_WAIT_CLR: begin
        if (!link.flush_busy) begin
          next_state = uiec_pkg::UIEC_HOST_IDLE;
        end
      end
      default: begin
        next_state = uiec_pkg::UIEC_HOST_IDLE;
      end
    endcase
    if (discard_i && !take && disc_cnt != uiec_pkg::UIEC_DISC_MAX) begin
      next_disc_cnt = disc_cnt + uiec_pkg::UIEC_DISC_ONE;
    end else if (take && !discard_i) begin
      next_disc_cnt = disc_cnt - uiec_pkg::UIEC_DISC_ONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state              <= uiec_pkg::UIEC_HOST_IDLE;
      disc_cnt           <= uiec_pkg::UIEC_DISC_ZERO;
      discard_pending_o  <= 1'b0;
      resp_valid_o       <= 1'b0;
      resp_kind_o        <= uiec_pkg::UIEC_RESP_NONE;
      link.in_token      <= 1'b0;
      link.sof           <= 1'b0;
      link.wr_ready      <= 1'b0;
      link.wr_stall      <= 1'b0;
      link.stall_value   <= 1'b0;
      link.wr_flush      <= 1'b0;
      link.clr_underrun  <= 1'b0;
      link.load_byte     <= 1'b0;
    end else if (ce_i) begin
      state              <= next_state;
      disc_cnt           <= next_disc_cnt;
      discard_pending_o  <= next_disc_cnt != uiec_pkg::UIEC_DISC_ZERO;
      resp_valid_o       <= link.resp_valid;
      resp_kind_o        <= link.resp_valid ? link.resp_kind : uiec_pkg::UIEC_RESP_NONE;
      link.in_token      <= tok_req_i;
      link.sof           <= sof_req_i;
      link.wr_ready      <= load_done_i;
      link.wr_stall      <= stall_set_i || stall_clr_i;
      link.stall_value   <= stall_set_i;
      link.wr_flush      <= next_flush;
      link.clr_underrun  <= clr_underrun_i;
      link.load_byte     <= load_byte_i;
    end
  end

endmodule

// ### testbench/uiec_asserts.sv
`timescale 1ns/1ps
module uiec_asserts (
  input wire logic                 core_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 in_token,
  input wire logic                 sof,
  input wire logic                 wr_ready,
  input wire logic                 wr_stall,
  input wire logic                 stall_value,
  input wire logic                 wr_flush,
  input wire logic                 clr_underrun,
  input wire logic                 resp_valid,
  input wire uiec_pkg::uiec_resp_t resp_kind,
  input wire logic                 in_packet_ready,
  input wire logic                 send_stall_request,
  input wire logic                 underrun_flag,
  input wire logic                 fifo_has_packets,
  input wire logic                 flush_busy
);
  // ---------------------------------------------------------------------------
  // Endpoint answers and status bits
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_token_answered: assert property (in_token |=> resp_valid)
    else $error("token not answered one cycle later");
  chk_nak_underrun: assert property (
    resp_valid && resp_kind == uiec_pkg::UIEC_RESP_NAK |-> underrun_flag)
    else $error("NAK answer without underrun flag");
  chk_zlp_underrun: assert property (
    resp_valid && resp_kind == uiec_pkg::UIEC_RESP_ZLP |-> underrun_flag)
    else $error("zero-length answer without underrun flag");
  chk_underrun_held: assert property (underrun_flag && !clr_underrun |=> underrun_flag)
    else $error("underrun flag dropped without a clear");
  // A stall written in the token's own cycle does not count yet in the dev end, but both are allowed.
  chk_stall_cause: assert property (resp_valid && resp_kind == uiec_pkg::UIEC_RESP_STALL
    |-> $past(send_stall_request) || ($past(wr_stall) && $past(stall_value)))
    else $error("STALL answer without a stall request");
  chk_stall_ended: assert property (wr_stall && !stall_value |=> !send_stall_request)
    else $error("stall request still set after a zero write");
  chk_flush_pulse: assert property (wr_flush |=> flush_busy ##1 !flush_busy)
    else $error("flush busy is not a single cycle");
  chk_flush_ready: assert property (flush_busy && !wr_ready && !sof |=> !in_packet_ready)
    else $error("ready flag set after a flush");
  chk_data_ready: assert property (resp_valid && resp_kind == uiec_pkg::UIEC_RESP_DATA
    |-> !in_packet_ready || $past(wr_ready) || $past(sof))
    else $error("ready flag kept after a data answer");
  chk_ready_has_pkts: assert property (in_packet_ready |-> fifo_has_packets)
    else $error("ready flag set with an empty FIFO");
  chk_empty_no_data: assert property (in_token && !fifo_has_packets && !wr_ready
    |=> resp_kind != uiec_pkg::UIEC_RESP_DATA)
    else $error("data answer from an empty FIFO");

  cov_data: cover property (resp_valid && resp_kind == uiec_pkg::UIEC_RESP_DATA);
  cov_stall: cover property (resp_valid && resp_kind == uiec_pkg::UIEC_RESP_STALL);
  cov_flush: cover property (wr_flush ##1 flush_busy ##1 !flush_busy);
endmodule

// ### testbench/usb_in_endpoint_control_test.sv
`timescale 1ns/1ps
module usb_in_endpoint_control_test;
  logic                            core_clk_i;
  logic                            resetn_i;
  logic                            tok, sof, lb, ld, ss, sc, disc, clru;
  logic                            iso, dbl, hold, irq_en, ep_irq, rv, pend;
  uiec_pkg::uiec_resp_t            rk;
  logic [uiec_pkg::UIEC_PTR_W-1:0] ptr;
  logic [uiec_pkg::UIEC_CNT_W-1:0] cnt;
  int                              fail_count;
  int                              comparisons;
  int                              irqs;
  int                              irq_mark;
  logic                            ce;
  uiec_link_if                     link ();

  uiec_host_end u_uiec_host_end (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce), .tok_req_i(tok),
    .sof_req_i(sof), .load_byte_i(lb), .load_done_i(ld), .stall_set_i(ss),
    .stall_clr_i(sc), .discard_i(disc), .clr_underrun_i(clru), .resp_valid_o(rv),
    .resp_kind_o(rk), .discard_pending_o(pend), .link(link)
  );
  uiec_dev_end u_uiec_dev_end (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce), .iso_mode_i(iso),
    .double_buffer_enable_i(dbl), .hold_until_frame_start_i(hold),
    .irq_enable_i(irq_en), .ep_irq_o(ep_irq), .fifo_ptr_o(ptr), .pkt_count_o(cnt),
    .link(link)
  );
  uiec_asserts u_uiec_asserts (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .in_token(link.in_token),
    .sof(link.sof), .wr_ready(link.wr_ready), .wr_stall(link.wr_stall),
    .stall_value(link.stall_value), .wr_flush(link.wr_flush),
    .clr_underrun(link.clr_underrun), .resp_valid(link.resp_valid),
    .resp_kind(link.resp_kind), .in_packet_ready(link.in_packet_ready),
    .send_stall_request(link.send_stall_request), .underrun_flag(link.underrun_flag),
    .fifo_has_packets(link.fifo_has_packets), .flush_busy(link.flush_busy)
  );

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (ep_irq === 1'b1) irqs <= irqs + 1;
  end

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Each host request is a single-cycle pulse; the wait after it covers the
  // forwarding stage plus the status update, so checks see settled values.
  task automatic pulse(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
    repeat (4) @(negedge core_clk_i);
  endtask

  task automatic token(input uiec_pkg::uiec_resp_t exp);
    int n;
    n = 0;
    @(negedge core_clk_i);
    tok = 1'b1;
    @(negedge core_clk_i);
    tok = 1'b0;
    while (rv !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("resp_valid", 10'h001, 10'(rv));
    chk("resp_kind", 10'(exp), 10'(rk));
    if (rv !== 1'b1) end_sim();
    repeat (3) @(negedge core_clk_i);
  endtask

  task automatic drop_packet();
    int n;
    pulse(disc);
    for (n = 0; n < 20 && (pend !== 1'b0 || link.flush_busy !== 1'b0); n++)
      @(negedge core_clk_i);
    chk("flush_idle", 10'h000, {8'h00, pend, link.flush_busy});
    if (n == 20) end_sim();
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    {tok, sof, lb, ld, ss, sc, disc, clru} = 8'h00;
    {iso, dbl, hold} = 3'h0;
    irq_en = 1'b1;
    fail_count = 0;
    comparisons = 0;
    irq_mark = 0;
    ce = 1'b1;
    resetn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk("ready", 10'h000, 10'(link.in_packet_ready));
    chk("has_packets", 10'h000, 10'(link.fifo_has_packets));
    $display("Test reset done");

    repeat (3) pulse(lb);
    pulse(ld);
    chk("fifo_ptr", 10'h003, ptr);
    chk("ready", 10'h001, 10'(link.in_packet_ready));
    chk("has_packets", 10'h001, 10'(link.fifo_has_packets));
    irq_mark = irqs;
    token(uiec_pkg::UIEC_RESP_DATA);
    chk("ready", 10'h000, 10'(link.in_packet_ready));
    chk("has_packets", 10'h000, 10'(link.fifo_has_packets));
    chk("irq", 10'h001, 10'(irqs - irq_mark));
    token(uiec_pkg::UIEC_RESP_NAK);
    chk("underrun", 10'h001, 10'(link.underrun_flag));
    pulse(clru);
    chk("underrun", 10'h000, 10'(link.underrun_flag));
    $display("Test bulk done");

    pulse(ss);
    chk("stall", 10'h001, 10'(link.send_stall_request));
    token(uiec_pkg::UIEC_RESP_STALL);
    pulse(sc);
    chk("stall", 10'h000, 10'(link.send_stall_request));
    token(uiec_pkg::UIEC_RESP_NAK);
    $display("Test stall done");

    dbl = 1'b1;
    pulse(lb);
    pulse(ld);
    chk("ready", 10'h000, 10'(link.in_packet_ready));
    pulse(lb);
    pulse(ld);
    chk("ready", 10'h001, 10'(link.in_packet_ready));
    chk("pkt_count", 10'h002, 10'(cnt));
    irq_mark = irqs;
    drop_packet();
    chk("pkt_count", 10'h001, 10'(cnt));
    chk("fifo_ptr", 10'h000, ptr);
    chk("ready", 10'h000, 10'(link.in_packet_ready));
    chk("irq", 10'h001, 10'(irqs - irq_mark));
    drop_packet();
    chk("has_packets", 10'h000, 10'(link.fifo_has_packets));
    $display("Test discard done");

    dbl = 1'b0;
    pulse(clru);
    iso = 1'b1;
    token(uiec_pkg::UIEC_RESP_ZLP);
    chk("underrun", 10'h001, 10'(link.underrun_flag));
    pulse(ss);
    token(uiec_pkg::UIEC_RESP_ZLP);
    pulse(sc);
    hold = 1'b1;
    pulse(lb);
    pulse(ld);
    chk("ready", 10'h000, 10'(link.in_packet_ready));
    chk("has_packets", 10'h001, 10'(link.fifo_has_packets));
    pulse(sof);
    chk("ready", 10'h001, 10'(link.in_packet_ready));
    irq_en = 1'b0;
    irq_mark = irqs;
    token(uiec_pkg::UIEC_RESP_DATA);
    chk("irq", 10'h000, 10'(irqs - irq_mark));
    $display("Test iso done");

    // With the enable low both ends hold still, so a ready write is never seen.
    {iso, hold} = 2'h0;
    ce = 1'b0;
    pulse(ld);
    ce = 1'b1;
    chk("ready_frozen", 10'h000, 10'(link.in_packet_ready));
    pulse(ld);
    chk("ready", 10'h001, 10'(link.in_packet_ready));
    $display("Test clock enable done");
    end_sim();
  end
endmodule
